/* File: tbr_store_readout.sv */
// trace buffer store and readout with an AHB-Lite register slave
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module tbr_store_readout (
  input  wire logic        sys_clk,         // system clock, 25 MHz
  input  wire logic        nrst,            // async reset, active low
  input  wire logic        hsel,            // slave select
  input  wire logic [31:0] haddr,           // byte address
  input  wire logic [1:0]  htrans,          // transfer type
  input  wire logic        hwrite,          // write when high
  input  wire logic [2:0]  hsize,           // transfer size
  input  wire logic [31:0] hwdata,          // write data
  input  wire logic        hready,          // bus ready
  output logic      [31:0] hrdata,          // read data
  output logic             hreadyout,       // slave ready
  output logic             hresp,           // response, always okay
  input  wire logic        secure_in,       // system secured, pin
  input  wire logic        flow_change,     // change of flow pulse
  input  wire logic        opcode_exec,     // opcode executed pulse
  input  wire logic        bus_cycle,       // cpu bus cycle pulse
  input  wire logic        opcode_fetch,    // cycle is opcode fetch
  input  wire logic        free_cycle,      // cycle is a free cycle
  input  wire logic [22:0] cap_addr,        // pc or access address
  input  wire logic        src_dst_flag,    // 1 destination address
  input  wire logic        vector_flag,     // 1 vector destination
  input  wire logic        access_size_flag,// 1 byte access
  input  wire logic        read_write_flag, // 1 read access
  input  wire logic [15:0] cap_data         // [15:8] lower address byte
);
  import tbr_pkg::*;

  logic             arm, trace_en, locked;
  tbr_mode_type     mode;
  logic [2:0]       sec_sync;
  logic             secured;
  logic [6:0]       trace_line_count;
  logic [5:0]       wr_line;
  logic             wrapped;
  logic             pair_half;
  logic [31:0]      first_entry;
  logic [22:0]      last_src;
  logic [5:0]       rd_line;
  logic [1:0]       rd_word;
  logic [63:0]      ram_q;
  logic             ap_valid, ap_write;
  logic [3:0]       ap_addr;
  logic [2:0]       ap_size;

  // register index match, used by the read and write decoders
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a[3:2] == o[3:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus address phase and wait state
  wire take_ap = hsel && htrans[1] && hready;
  wire rd_done = ap_valid && !ap_write && !hreadyout;
  wire wr_done = ap_valid && ap_write;
  wire acc_ok  = (ap_size != 3'h0) && (ap_addr[1:0] == 2'h0);

  // reads get one wait state so ram data has settled after a step
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= 4'h0;
      ap_size   <= 3'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ap_valid  <= take_ap;
      hreadyout <= !(take_ap && !hwrite);
      if (take_ap) begin
        ap_write <= hwrite;
        ap_addr  <= haddr[3:0];
        ap_size  <= hsize;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and read lock
  wire wr_ctrl = wr_done && hit(ap_addr, OFS_CTRL);
  wire arm_set = wr_ctrl && hwdata[CTRL_ARM_BIT] && !arm;
  wire win_wr  = wr_done && acc_ok &&
                 (hit(ap_addr, OFS_WINDOW) || hit(ap_addr, OFS_HIGH_WORD));
  wire unlock  = win_wr && !arm;
  wire hi_wr   = wr_done && acc_ok && hit(ap_addr, OFS_HIGH_WORD);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arm      <= 1'b0;
      trace_en <= 1'b0;
      mode     <= tbr_mode_type'(CTRL_MODE_RST);
      locked   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        arm      <= hwdata[CTRL_ARM_BIT];
        trace_en <= hwdata[CTRL_EN_BIT];
        mode     <= tbr_mode_type'(hwdata[CTRL_MODE_LSB +: 2]);
      end
      if (wr_ctrl && hwdata[CTRL_ARM_BIT]) begin
        locked <= 1'b1;
      end else if (unlock) begin
        locked <= 1'b0;
      end
    end
  end

  // secure pin: three stages, change taken once the last two agree
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sec_sync <= 3'h0;
      secured  <= 1'b0;
    end else begin
      sec_sync <= {sec_sync[1:0], secure_in};
      if (sec_sync[1] == sec_sync[2]) begin
        secured <= sec_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture: choose event and build entry or detail line
  wire detail  = (mode == MODE_DETAIL);
  wire active  = arm && trace_en;
  // a vector entry is a destination even when the source flag is low
  wire is_source  = !src_dst_flag && !vector_flag;
  wire repeat_hit = (mode == MODE_REPEAT) && is_source &&
                    (cap_addr == last_src);
  logic        take;
  logic [7:0]  info;
  logic [31:0] entry;
  logic [15:0] dword;
  logic [63:0] ram_wdata;

  always_comb begin
    take  = 1'b0;
    info  = 8'h00;
    dword = cap_data;
    unique case (mode)
      MODE_NORMAL, MODE_REPEAT: begin
        take = active && flow_change && !repeat_hit;
        info[INF_SRC_DST] = src_dst_flag || vector_flag;
        info[INF_VECTOR]  = vector_flag;
        info[INF_VALID]   = 1'b1;
      end
      MODE_ALLOP: begin
        take = active && opcode_exec;
        info[INF_VALID] = 1'b1;
      end
      MODE_DETAIL: begin
        take = active && bus_cycle && !opcode_fetch && !free_cycle;
        info[INF_SIZE] = access_size_flag;
        info[INF_READ] = read_write_flag;
        if (access_size_flag) begin
          dword = {8'h00, cap_data[7:0]};
        end
      end
    endcase
    entry = {info, 1'b0, cap_addr};
    // detail line: info, address, data, two unused bytes
    if (detail) begin
      ram_wdata = {entry, dword, 16'h0000};
    end else if (pair_half) begin
      ram_wdata = {entry, first_entry};
    end else begin
      ram_wdata = {32'h0000_0000, entry};
    end
  end

  // count, write line and wrap flag have no reset: they outlive it
  wire cnt_full = (trace_line_count[6:1] == LAST_LINE) &&
                  (detail || trace_line_count[0]);
  wire line_end = detail || pair_half;

  always_ff @(posedge sys_clk) begin
    if (arm_set) begin
      trace_line_count <= 7'h00;
      wr_line          <= 6'h00;
      wrapped          <= 1'b0;
      pair_half        <= 1'b0;
    end else if (take) begin
      // pair position kept apart so a saturated count keeps the layout
      if (!detail) begin
        pair_half <= !pair_half;
      end
      if (detail) begin
        trace_line_count <= cnt_full ? CNT_MAX - 7'h01 :
                            {trace_line_count[6:1] + 6'h01, 1'b0};
      end else if (!cnt_full) begin
        trace_line_count <= trace_line_count + 7'h01;
      end
      if (line_end) begin
        wr_line <= wr_line + 6'h01;
        if (wr_line == LAST_LINE) begin
          wrapped <= 1'b1;
        end
      end
    end
  end

  // earlier entry kept so the pair line can be rewritten whole
  always_ff @(posedge sys_clk) begin
    if (take && !detail && !pair_half) begin
      first_entry <= entry;
    end
    if (take && !detail && is_source) begin
      last_src <= cap_addr;
    end
  end

  tbr_line_ram #(
    .AW(LINE_AW),
    .DW(LINE_BITS)
  ) u_ram (
    .sys_clk(sys_clk),
    .we     (take),
    .waddr  (wr_line),
    .wdata  (ram_wdata),
    .raddr  (rd_line),
    .rdata  (ram_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // readout pointer
  wire [5:0] oldest  = wrapped ? wr_line : 6'h00;
  wire       read_ok = !arm && trace_en && !secured && !locked;
  wire       win_rd  = rd_done && acc_ok && hit(ap_addr, OFS_WINDOW);
  wire       advance = win_rd && read_ok;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_line <= 6'h00;
      rd_word <= 2'h0;
    end else if (unlock || hi_wr) begin
      rd_line <= oldest;
      rd_word <= 2'h0;
    end else if (advance) begin
      rd_word <= rd_word + 2'h1;
      if (rd_word == LAST_WORD) begin
        rd_line <= rd_line + 6'h01;
      end
    end
  end

  // read data; refused window reads, high word reads and byte or misaligned reads give zero, control and count their value
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_done) begin
      hrdata <= 32'h0000_0000;
      if (!acc_ok) begin
        hrdata <= 32'h0000_0000;
      end else if (hit(ap_addr, OFS_CTRL)) begin
        hrdata[CTRL_ARM_BIT]        <= arm;
        hrdata[CTRL_EN_BIT]         <= trace_en;
        hrdata[CTRL_MODE_LSB +: 2]  <= mode;
        hrdata[CTRL_LOCK_BIT]       <= locked;
        hrdata[CTRL_SEC_BIT]        <= secured;
      end else if (hit(ap_addr, OFS_LINE_CNT)) begin
        hrdata[6:0] <= trace_line_count;
      end else if (advance) begin
        hrdata[15:0] <= ram_q[16*rd_word +: 16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  AST_CNT_STEP: assert property (
    take && !detail && !arm_set && !cnt_full && !wr_ctrl
    |=> trace_line_count == $past(trace_line_count) + 7'h01)
    else $error("count did not step by one entry");

  AST_CNT_DETAIL: assert property (
    take && detail && !arm_set |=> trace_line_count[0] == 1'b0)
    else $error("count bit 0 set in detail mode");

  AST_VALID_SET: assert property (
    take && !detail |-> ram_wdata[24 + INF_VALID] && info[INF_VALID])
    else $error("stored entry not marked valid");

  AST_BYTE_DATA: assert property (
    take && detail && access_size_flag
    |-> ram_wdata[31:16] == {8'h00, cap_data[7:0]})
    else $error("byte access not in low data byte");

  AST_VECTOR_DST: assert property (
    take && !detail && info[INF_VECTOR] |-> info[INF_SRC_DST])
    else $error("vector entry without destination bit");

  AST_DETAIL_SKIP: assert property (
    active && detail && (opcode_fetch || free_cycle) |-> !take)
    else $error("fetch or free cycle captured");

  AST_ARMED_READ: assert property (
    win_rd && arm |=> hrdata == 32'h0000_0000 && $stable(rd_line)
    && $stable(rd_word))
    else $error("armed read returned data or moved pointer");

  AST_BAD_ACCESS: assert property (
    rd_done && !acc_ok |=> hrdata == 32'h0000_0000 && $stable(rd_word))
    else $error("byte or misaligned read not zero");

  AST_LINE_HOLD: assert property (
    advance && rd_word != LAST_WORD && !unlock && !hi_wr
    |=> $stable(rd_line) && rd_word == $past(rd_word) + 2'h1)
    else $error("pointer left line early");

  AST_REWIND: assert property (
    hi_wr |=> rd_line == $past(oldest) && rd_word == 2'h0)
    else $error("high word write did not rewind");

  AST_LOCK: assert property (
    wr_ctrl && hwdata[CTRL_ARM_BIT] |=> locked ##1 !read_ok)
    else $error("arming did not lock the buffer");
endmodule // tbr_store_readout

/* File: tbr_pkg.sv */
// constants shared by the trace buffer store and readout logic
package tbr_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_LINE_CNT  = 4'h4;
  localparam logic [3:0] OFS_WINDOW    = 4'h8;
  localparam logic [3:0] OFS_HIGH_WORD = 4'hc;
  // control register fields
  localparam int CTRL_ARM_BIT  = 0;
  localparam int CTRL_EN_BIT   = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_LOCK_BIT = 4;
  localparam int CTRL_SEC_BIT  = 5;
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  // information byte bit positions
  localparam int INF_SRC_DST = 7;
  localparam int INF_VECTOR  = 6;
  localparam int INF_VALID   = 4;
  localparam int INF_SIZE    = 6;
  localparam int INF_READ    = 5;
  // line count saturation and buffer shape
  localparam logic [6:0] CNT_MAX   = 7'h7f;
  localparam int         LINE_BITS = 64;
  localparam int         LINE_AW   = 6;
  localparam logic [5:0] LAST_LINE = 6'h3f;
  localparam logic [1:0] LAST_WORD = 2'h3;
  // trace modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_DETAIL = 2'b10,
    MODE_ALLOP  = 2'b11
  } tbr_mode_type;
endpackage

/* File: tbr_line_ram.sv */
// line memory of the trace buffer with registered read data
`timescale 1ns/10ps
module tbr_line_ram #(
  parameter int AW = 6,
  parameter int DW = 64
) (
  input  wire logic          sys_clk, // system clock
  input  wire logic          we,      // write strobe
  input  wire logic [AW-1:0] waddr,   // write line
  input  wire logic [DW-1:0] wdata,   // write data
  input  wire logic [AW-1:0] raddr,   // read line
  output logic      [DW-1:0] rdata    // read data, one cycle late
);
  logic [DW-1:0] mem [2**AW];

  // no reset: contents must outlive a system reset
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // tbr_line_ram

/* File: tbr_host.sv */
// host model: single AHB-Lite transfers of any size and alignment into the registers
`timescale 1ns/10ps
module tbr_host (
  input  wire logic        sys_clk, // system clock
  input  wire logic        hready,  // bus ready
  input  wire logic [31:0] hrdata,  // read data
  output logic             hsel,    // slave select
  output logic      [31:0] haddr,   // byte address
  output logic      [1:0]  htrans,  // transfer type
  output logic             hwrite,  // write when high
  output logic      [2:0]  hsize,   // transfer size
  output logic      [31:0] hwdata   // write data
);
  // bus starts idle
  initial begin
    {hsel, htrans, hwrite} = 4'h0;
    {haddr, hwdata} = 64'h0;
    hsize = 3'h2;
  end
  // address phase held until ready, then the data phase; released lines
  // are inverted so a stale value cannot pass for a fresh one
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [2:0] sz, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge sys_clk);
    {hsel, htrans, hwrite, hsize} <= {1'b1, 2'h2, w, sz};
    haddr <= a;
    do @(posedge sys_clk); while (hready !== 1'b1);
    {hsel, htrans} <= 3'h0;
    haddr  <= ~a;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
  // reads of the window are whole aligned words
  task automatic rd_word(input logic [31:0] a, output logic [31:0] rd);
    xfer(1'b0, a, 3'h2, 32'h0, rd);
  endtask
  // unlocking takes an aligned word write
  task automatic wr_word(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] g;
    xfer(1'b1, a, 3'h2, d, g);
  endtask
endmodule // tbr_host

/* File: testbench.sv */
// self-checking bench: capture in all modes, persistence, window readout
`timescale 1ns/10ps
module testbench;
  import tbr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, secure_in;
  logic        flow_change, opcode_exec, bus_cycle, opcode_fetch;
  logic        free_cycle, src_dst_flag, vector_flag;
  logic        access_size_flag, read_write_flag;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [22:0] cap_addr, last_src;
  logic [15:0] cap_data;
  logic [63:0] mem [64];
  int          wl, cnt, mismatches, samples_checked;
  bit          half, wrap;
  tbr_mode_type cur;
  ////////////////////////////////////////////////////////////////////////
  tbr_store_readout i_tbr_store_readout (.sys_clk(sys_clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .secure_in(secure_in),
    .flow_change(flow_change), .opcode_exec(opcode_exec),
    .bus_cycle(bus_cycle), .opcode_fetch(opcode_fetch),
    .free_cycle(free_cycle), .cap_addr(cap_addr),
    .src_dst_flag(src_dst_flag), .vector_flag(vector_flag),
    .access_size_flag(access_size_flag),
    .read_write_flag(read_write_flag), .cap_data(cap_data));
  tbr_host i_tbr_host (.sys_clk(sys_clk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // 25 MHz
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////
  // buffer model: circular lines, half-line flag, saturating count
  function automatic void adv();
    wl = (wl + 1) % 64;
    if (wl == 0) wrap = 1'b1;
  endfunction
  function automatic void put_half(input logic [31:0] e);
    if (!half) mem[wl] = {32'h0, e};
    else mem[wl][63:32] = e;
    half = !half;
    cnt = (cnt == 127) ? 127 : cnt + 1;
    if (!half) adv();
  endfunction
  function automatic void put_line(input logic [63:0] l);
    mem[wl] = l;
    cnt = (cnt >= 126) ? 126 : cnt + 2;
    adv();
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] g;
    i_tbr_host.rd_word(a, g);
    chk(g, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // one capture pulse with random fields; qualifiers may void it
  task automatic cap();
    logic [22:0] a;
    logic [15:0] d;
    logic [1:0]  ff;
    logic        sd, va, sz, rw;
    a = (cur == MODE_REPEAT) ? 23'($urandom_range(1, 2)) : 23'($urandom);
    {sd, va, sz, rw, d} = 20'($urandom);
    ff = 2'($urandom) & 2'($urandom);
    if (cur == MODE_REPEAT && cnt == 0) {a, sd, va} = {23'h3, 2'b00};
    @(posedge sys_clk);
    {cap_addr, src_dst_flag, vector_flag} <= {a, sd, va};
    {access_size_flag, read_write_flag, cap_data} <= {sz, rw, d};
    {opcode_fetch, free_cycle} <= ff;
    {flow_change, opcode_exec, bus_cycle} <= (cur == MODE_DETAIL) ? 3'h1 :
                                            (cur == MODE_ALLOP) ? 3'h2 : 3'h4;
    @(posedge sys_clk);
    {flow_change, opcode_exec, bus_cycle} <= 3'h0;
    if (cur == MODE_DETAIL) begin
      if (ff == 2'b00) put_line({1'b0, sz, rw, 5'h0, 1'b0, a,
                                 sz ? {8'h00, d[7:0]} : d, 16'h0});
    end else if (cur == MODE_ALLOP) put_half({8'h10, 1'b0, a});
    else if (cur != MODE_REPEAT || sd || va || a != last_src) begin
      put_half({sd | va, va, 2'b01, 4'h0, 1'b0, a});
      if (!(sd || va)) last_src = a;
    end
  endtask
  // read up to k lines from the oldest, four words each
  task automatic readout(input int k);
    int nl;
    int ln;
    logic [31:0] g;
    nl = wrap ? 64 : wl + int'(half);
    if (k < nl) nl = k;
    for (int i = 0; i < nl; i++) begin
      ln = ((wrap ? wl : 0) + i) % 64;
      for (int j = 0; j < 4; j++) begin
        if (i == 0 && j == 1) begin
          i_tbr_host.xfer(1'b0, OFS_WINDOW, 3'h0, 32'h0, g);
          chk(g, 32'h0);
          i_tbr_host.xfer(1'b0, OFS_WINDOW + 2, 3'h2, 32'h0, g);
          chk(g, 32'h0);
        end
        rd_chk(OFS_WINDOW, {16'h0, mem[ln][16*j +: 16]});
      end
    end
  endtask
  // one trace session in mode m with n capture attempts
  task automatic sess(input tbr_mode_type m, input int n);
    logic [31:0] c;
    cur = m;
    c = (32'h1 << CTRL_ARM_BIT) | (32'h1 << CTRL_EN_BIT);
    c = c | (32'(m) << CTRL_MODE_LSB);
    {half, wrap} = 2'b00;
    wl = 0;
    cnt = 0;
    i_tbr_host.wr_word(OFS_CTRL, c);
    rd_chk(OFS_CTRL, c | (32'h1 << CTRL_LOCK_BIT));
    rd_chk(OFS_WINDOW, 32'h0);
    repeat (n) cap();
    i_tbr_host.wr_word(OFS_CTRL, c & ~32'h1);
    rd_chk(OFS_WINDOW, 32'h0);
    rd_chk(OFS_LINE_CNT, 32'(cnt));
    i_tbr_host.wr_word(OFS_WINDOW, 32'h0);
    readout(1);
    i_tbr_host.wr_word(OFS_HIGH_WORD, 32'h0);
    secure_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd_chk(OFS_WINDOW, 32'h0);
    secure_in <= 1'b0;
    repeat (6) @(posedge sys_clk);
    readout(64);
    rd_chk(OFS_LINE_CNT, 32'(cnt));
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the expected run of about 2,500 cycles
  initial begin
    #2_000_000;
    mismatches++;
    tally_and_finish();
  end
  // main sequence; the mid-run reset checks that trace state survives
  initial begin
    {secure_in, flow_change, opcode_exec, bus_cycle} = 4'h0;
    {opcode_fetch, free_cycle, src_dst_flag, vector_flag} = 4'h0;
    {access_size_flag, read_write_flag, cap_addr, cap_data} = 41'h0;
    void'($urandom(32'h0e60396f));
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(OFS_CTRL, 32'h0);
    sess(MODE_NORMAL, 140);
    sess(MODE_REPEAT, 21);
    sess(MODE_DETAIL, 41);
    sess(MODE_ALLOP, 11);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(OFS_WINDOW, 32'h0);
    i_tbr_host.wr_word(OFS_CTRL, 32'h1 << CTRL_EN_BIT);
    rd_chk(OFS_LINE_CNT, 32'(cnt));
    i_tbr_host.wr_word(OFS_WINDOW, 32'h0);
    readout(64);
    tally_and_finish();
  end
endmodule // testbench
